// ===== shared/psr_defs.svh
// Summary of operation
// RULE1 - load low copies the eight parallel inputs into the stages
// RULE2 - load overrides clocking; stages follow parallel inputs while load low
// RULE3 - load high: each edge shifts serial input into stage 0, others move up; a full fifo holds one edge and drops later ones
// RULE4 - effective shift clock is the OR of both clock inputs
// RULE5 - either clock held high inhibits shifts; the other acts as enable
// RULE6 - inhibit rising while other clock low gives exactly one shift
// RULE7 - controller raises the inhibit only while the other clock is high; the inhibit() task raises clock b while clock a is low
// RULE8 - last stage drives true serial output and its inverse at all times
// RULE9 - controller holds load high to shift, releases it before first edge; test_load raises clock a while load is low
// RULE10 - synchronous form: load first, OR clock via a registered edge detect
`ifndef PSR_DEFS_SVH
`define PSR_DEFS_SVH
`define PSR_STAGES        8
`define PSR_FIFO_DEPTH    16
`define PSR_FIFO_WIDTH    1
`define PSR_STAGE_RESET   8'h00
`define PSR_CLK_PREV_RST  1'b1
`endif

// ===== shared/psr_pkg.sv
`include "psr_defs.svh"
package psr_pkg;
   typedef logic [`PSR_STAGES-1:0] psr_stages_t;

   typedef struct packed {
      psr_stages_t stage;
      logic        clk_or_prev;
      logic        pending;
   } psr_state_t;
endpackage : psr_pkg

// ===== hw/psr_shift_register.sv
`timescale 1ns/1ps
`include "psr_defs.svh"

module psr_fifo #(
   parameter int WIDTH = `PSR_FIFO_WIDTH,
   parameter int DEPTH = `PSR_FIFO_DEPTH
) (
   input  wire logic             sys_clk,
   input  wire logic             rst_b,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr_ptr;
      logic [AW-1:0]               rd_ptr;
      logic [AW:0]                 count;
   } psr_fifo_state_t;

   psr_fifo_state_t st_reg;
   psr_fifo_state_t st_next;
   logic            push;
   logic            pop;

   // pointers wrap by overflow, so only powers of two are served
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
   begin : g_param_check
      $error("fifo depth must be a power of two >= 2, width >= 1");
   end

   assign in_ready  = (st_reg.count != (AW+1)'(DEPTH));
   assign out_valid = (st_reg.count != '0);
   assign out_data  = st_reg.mem[st_reg.rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb
   begin
      st_next = st_reg;
      if (push)
      begin
         st_next.mem[st_reg.wr_ptr] = in_data;
         st_next.wr_ptr = st_reg.wr_ptr + AW'(1);
      end
      if (pop)
         st_next.rd_ptr = st_reg.rd_ptr + AW'(1);
      if (push && !pop)
         st_next.count = st_reg.count + (AW+1)'(1);
      else if (pop && !push)
         st_next.count = st_reg.count - (AW+1)'(1);
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         st_reg.mem    <= '0;
         st_reg.wr_ptr <= '0;
         st_reg.rd_ptr <= '0;
         st_reg.count  <= '0;
      end
      else
         st_reg <= st_next;
   end
endmodule : psr_fifo

module psr_shift_register (
   input  wire logic                   sys_clk,
   input  wire logic                   rst_b,
   input  wire logic                   parallel_load_n,
   input  wire logic                   shift_clock_a,
   input  wire logic                   shift_clock_b,
   input  wire logic                   serial_in,
   input  wire psr_pkg::psr_stages_t   parallel_in,
   output logic                        serial_out,
   output logic                        serial_out_inverted,
   output logic                        shifted_valid,
   input  wire logic                   shifted_ready,
   output logic                        shifted_bit
);
   import psr_pkg::*;

   localparam int LAST = `PSR_STAGES - 1;

   psr_state_t  st_reg;
   psr_state_t  st_next;
   logic        clk_or;
   logic        rise;
   logic        shift_req;
   logic        do_shift;
   logic        fifo_in_ready;
   logic        last_bit;
   psr_stages_t shifted_stages;

   // the shift path needs a stage before the last one
   if (`PSR_STAGES < 2)
   begin : g_stage_check
      $error("shift register needs at least two stages");
   end

   assign clk_or = shift_clock_a | shift_clock_b; // [RULE4] [RULE5]
   // a rise of either input while the other is low counts as one edge
   assign rise   = clk_or & ~st_reg.clk_or_prev; // [RULE6] [RULE10]
   // an edge held while the fifo was full is served once; new edges before that merge into it
   assign shift_req = parallel_load_n & (rise | st_reg.pending);
   // a full fifo stalls the shift; one edge waits, further edges while full are dropped
   assign do_shift  = shift_req & fifo_in_ready;
   assign last_bit  = st_reg.stage[LAST];
   assign shifted_stages = {st_reg.stage[LAST-1:0], serial_in}; // [RULE3]

   always_comb
   begin
      st_next             = st_reg;
      st_next.clk_or_prev = clk_or;
      if (!parallel_load_n)
      begin
         // load wins and clears any waiting edge
         st_next.stage   = parallel_in; // [RULE1] [RULE2] [RULE10]
         st_next.pending = 1'b0; // [RULE2]
      end
      else if (do_shift)
      begin
         st_next.stage   = shifted_stages; // [RULE3]
         st_next.pending = 1'b0;
      end
      else if (rise)
         st_next.pending = 1'b1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         st_reg.stage       <= `PSR_STAGE_RESET;
         // high at reset so a clock already high gives no false edge
         st_reg.clk_or_prev <= `PSR_CLK_PREV_RST;
         st_reg.pending     <= 1'b0;
      end
      else
         st_reg <= st_next;
   end

   assign serial_out          = last_bit; // [RULE8]
   assign serial_out_inverted = ~last_bit; // [RULE8]

   psr_fifo #(
      .WIDTH (`PSR_FIFO_WIDTH),
      .DEPTH (`PSR_FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rst_b     (rst_b),
      .in_valid  (shift_req),
      .in_ready  (fifo_in_ready),
      .in_data   (last_bit),
      .out_valid (shifted_valid),
      .out_ready (shifted_ready),
      .out_data  (shifted_bit)
   );
endmodule : psr_shift_register

// ===== testbench/psr_shift_register_props.sv
`timescale 1ns/1ps
module psr_shift_register_props (
   input wire logic sys_clk, rst_b, parallel_load_n, shift_clock_a,
   input wire logic shift_clock_b, serial_out, serial_out_inverted,
   input wire logic shifted_valid, shifted_ready, shifted_bit,
   input wire psr_pkg::psr_stages_t parallel_in
);
   wire s = shift_clock_a | shift_clock_b;
   wire ld = parallel_load_n;
   wire v = shifted_valid;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // an empty fifo rules out a held pending edge
   property p_load; !ld |=> serial_out == $past(parallel_in[7]); endproperty
   a_load: assert property (p_load) else $error("load");
   property p_over; !ld && !v |=> !v; endproperty
   a_over: assert property (p_over) else $error("over");
   property p_shift; ld && s && !$past(s) && $past(rst_b) && !v
      |=> v && shifted_bit == $past(serial_out); endproperty
   a_shift: assert property (p_shift) else $error("shift");
   property p_idle; ld && !s && !v |=> $stable(serial_out); endproperty
   a_idle: assert property (p_idle) else $error("idle");
   property p_hold; ld && s && $past(s) && !v |=> $stable(serial_out);
   endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_b; ld && shift_clock_b && !$past(s) && $past(rst_b) && !v
      |=> v; endproperty
   a_b: assert property (p_b) else $error("b rise");
   property p_inv; serial_out_inverted == !serial_out; endproperty
   a_inv: assert property (p_inv) else $error("inv");
   property p_keep; v && !shifted_ready |=> v && $stable(shifted_bit);
   endproperty
   a_keep: assert property (p_keep) else $error("keep");
   c_load: cover property (!ld ##1 ld);
   c_pop: cover property (v && shifted_ready);
   c_inh: cover property (shift_clock_b && $rose(shift_clock_a));
endmodule : psr_shift_register_props
bind psr_shift_register psr_shift_register_props i_props (.*);

// ===== testbench/psr_ctl.sv
`timescale 1ns/1ps
module psr_ctl (
   input wire logic sys_clk,
   output logic parallel_load_n, shift_clock_a, shift_clock_b, serial_in,
   output psr_pkg::psr_stages_t parallel_in
);
   initial {parallel_load_n, shift_clock_a, shift_clock_b, serial_in} = 4'h8;
   initial parallel_in = 8'h00;
   task automatic load(input psr_pkg::psr_stages_t d);
      @(posedge sys_clk) {parallel_load_n, parallel_in} <= {1'b0, d};
      @(posedge sys_clk) parallel_load_n <= 1'b1;
   endtask : load
   // one low and one high cycle per shift, the fastest legal rate
   task automatic pulse();
      @(posedge sys_clk) {serial_in, shift_clock_a} <= 2'h3;
      @(posedge sys_clk) shift_clock_a <= 1'b0;
   endtask : pulse
   task automatic inhibit();
      @(posedge sys_clk) shift_clock_b <= 1'b1;
   endtask : inhibit
   // inhibit dropped, then raised again only while clock a is high
   task automatic safe_inhibit();
      @(posedge sys_clk) shift_clock_b <= 1'b0;
      @(posedge sys_clk) shift_clock_a <= 1'b1;
      @(posedge sys_clk) shift_clock_b <= 1'b1;
      @(posedge sys_clk) shift_clock_a <= 1'b0;
   endtask : safe_inhibit
endmodule : psr_ctl

// ===== testbench/psr_shift_register_test.sv
`timescale 1ns/1ps
module psr_shift_register_test;
   logic sys_clk = 1'b0, rst_b = 1'b0, shifted_ready = 1'b0;
   logic parallel_load_n, shift_clock_a, shift_clock_b, serial_in;
   logic serial_out, serial_out_inverted, shifted_valid, shifted_bit;
   psr_pkg::psr_stages_t parallel_in;
   int err_count, n_checks, cyc;
   psr_shift_register i_dut (.*);
   psr_ctl i_ctl (.*);
   initial forever #10 sys_clk = !sys_clk;
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done
   // the whole run needs about two hundred cycles; a hang ends here
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         err_count++;
         $display("[FAIL] %0t timeout", $time);
         test_done();
      end
   end
   task automatic chk(input logic got, input logic exp);
      n_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t mismatch", $time);
      end
   endtask : chk
   task automatic drain(input psr_pkg::psr_stages_t d, input int n);
      int k = 0;
      @(posedge sys_clk) shifted_ready <= 1'b1;
      repeat (40) @(negedge sys_clk) if (shifted_valid)
      begin
         chk(shifted_bit, k < 8 ? d[7-k] : 1'b1);
         k++;
      end
      chk(k == n, 1'b1);
      @(posedge sys_clk) shifted_ready <= 1'b0;
   endtask : drain
   task automatic test_load();
      fork i_ctl.load(8'h5A); i_ctl.pulse(); join
      @(negedge sys_clk);
      chk(serial_out, 1'b0);
      chk(serial_out_inverted, 1'b1);
      chk(shifted_valid, 1'b0);
      $display("load test done");
   endtask : test_load
   task automatic test_stream();
      repeat (17) i_ctl.pulse();
      drain(8'h5A, 17);
      $display("stream test done");
   endtask : test_stream
   task automatic test_inhibit();
      i_ctl.inhibit();
      repeat (2) i_ctl.pulse();
      drain(8'hFF, 1);
      $display("inhibit test done");
   endtask : test_inhibit
   task automatic test_safe();
      i_ctl.safe_inhibit();
      drain(8'hFF, 1);
      $display("safe inhibit test done");
   endtask : test_safe
   initial
   begin
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      test_load();
      test_stream();
      test_inhibit();
      test_safe();
      test_done();
   end
endmodule : psr_shift_register_test
